// File: hw/ptss_filter.sv
// Input synchroniser and settle-time filter for one group of external inputs.
`default_nettype none
module ptss_filter (
    input  wire logic                     clk,       // System clock
    input  wire logic                     rst,       // Synchronous reset
    input  wire logic [ptss_pkg::IN_W-1:0] raw_in,   // Asynchronous pin levels
    input  wire logic [3:0]               filt_set,  // Filter setting in steps
    output logic      [ptss_pkg::IN_W-1:0] filt_out  // Filtered levels
);
    logic [ptss_pkg::IN_W-1:0] sync1_ff, sync2_ff, nxt_sync1, nxt_sync2;
    logic [ptss_pkg::IN_W-1:0] out_ff, nxt_out;
    logic [ptss_pkg::FILT_W-1:0] cnt_ff [ptss_pkg::IN_W];
    logic [ptss_pkg::FILT_W-1:0] nxt_cnt [ptss_pkg::IN_W];
    logic [ptss_pkg::FILT_W-1:0] limit;

    assign filt_out = out_ff;

    // A bit is taken only after it has differed from the output for the whole setting.
    always_comb begin
        nxt_sync1 = raw_in;
        nxt_sync2 = sync1_ff;
        nxt_out   = out_ff;
        limit     = ptss_pkg::FILT_W'(filt_set * ptss_pkg::FILT_STEP_CYC);
        for (int i = 0; i < ptss_pkg::IN_W; i++) begin
            nxt_cnt[i] = '0;
            if (sync2_ff[i] != out_ff[i]) begin
                if (cnt_ff[i] >= limit) begin
                    nxt_out[i] = sync2_ff[i];
                end else begin
                    nxt_cnt[i] = ptss_pkg::FILT_W'(cnt_ff[i] + 1'b1);
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            sync1_ff <= '0;
            sync2_ff <= '0;
            out_ff   <= '0;
            for (int i = 0; i < ptss_pkg::IN_W; i++) begin
                cnt_ff[i] <= '0;
            end
        end else begin
            sync1_ff <= nxt_sync1;
            sync2_ff <= nxt_sync2;
            out_ff   <= nxt_out;
            for (int i = 0; i < ptss_pkg::IN_W; i++) begin
                cnt_ff[i] <= nxt_cnt[i];
            end
        end
    end
endmodule : ptss_filter
`default_nettype wire

// File: hw/ptss_pkg.sv
// Package for the point-table start sequencer: constants, table layout and carriers.
`default_nettype none
package ptss_pkg;
    localparam int          TABLE_COUNT     = 16;
    localparam int          TABLE_FIRST     = 1;
    localparam int          TABLE_LAST      = 15;
    localparam int          POS_W           = 32;
    localparam int          SPD_W           = 16;
    localparam int          TIME_W          = 16;
    localparam int          AUX_W           = 2;
    localparam logic [3:0]  CMD_ABSOLUTE    = 4'h0;
    localparam logic [3:0]  CMD_INCREMENTAL = 4'h1;
    localparam int          CMD_DIGIT_LSB   = 0;
    // Wide enough for the longest setting of fifteen steps.
    localparam int          FILT_W          = 21;
    localparam int          CLK_HZ          = 100_000_000;
    // One filter step per unit of the filter setting.
    localparam int          FILT_STEP_US    = 1000;
    localparam int          FILT_STEP_CYC   = (CLK_HZ / 1_000_000) * FILT_STEP_US;
    localparam logic [3:0]  FILT_RESET      = 4'h0;
    localparam logic [15:0] PARAM0_RESET    = 16'h0000;
    localparam int          IN_W            = 9;
    localparam int          IN_AUTO         = 0;
    localparam int          IN_SEL_LSB      = 1;
    localparam int          IN_FWD          = 5;
    localparam int          IN_REV          = 6;
    localparam int          IN_SON          = 7;
    localparam int          IN_READY        = 8;

    typedef struct packed {
        logic signed [POS_W-1:0] position;
        logic [SPD_W-1:0]        speed;
        logic [TIME_W-1:0]       accel_time;
        logic [TIME_W-1:0]       decel_time;
        logic [TIME_W-1:0]       dwell_time;
        logic [AUX_W-1:0]        aux_func;
    } ptss_entry_type;

    typedef struct packed {
        logic                    incremental;
        logic                    reverse;
        logic [3:0]              table_no;
        logic signed [POS_W-1:0] position;
        logic [SPD_W-1:0]        speed;
        logic [TIME_W-1:0]       accel_time;
        logic [TIME_W-1:0]       decel_time;
        logic [TIME_W-1:0]       dwell_time;
        logic [AUX_W-1:0]        aux_func;
    } ptss_move_type;
endpackage : ptss_pkg
`default_nettype wire

// File: hw/ptss_top.sv
// Point-table start sequencer: filtered inputs, table store and move launch.
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module ptss_top (
    input  wire logic                         CLK_SYS,      // 100 MHz system clock
    input  wire logic                         RST,          // Synchronous reset, active high
    input  wire logic                         AUTO_MANUAL_SELECT, // Auto mode pin
    input  wire logic [3:0]                   TABLE_SELECT, // Table select bits 3..0
    input  wire logic                         FORWARD_START, // Forward start pin
    input  wire logic                         REVERSE_START, // Reverse start pin
    input  wire logic                         SERVO_ON,     // Servo-on pin
    input  wire logic                         READY,        // Ready from power stage
    input  wire logic                         TROUBLE_FLAG, // Trouble state, same clock
    input  wire logic [15:0]                  PARAM0,       // Parameter zero setting
    input  wire logic [3:0]                   PARAM2_FILTER, // Parameter 2 filter setting
    input  wire logic                         TBL_WE,       // Table entry write strobe
    input  wire logic [3:0]                   TBL_ADDR,     // Table entry number
    input  wire ptss_pkg::ptss_entry_type     TBL_WDATA,    // Table entry write data
    input  wire logic                         MOVE_DONE,    // Profile generator finished
    output var ptss_pkg::ptss_entry_type      TBL_RDATA,    // Table entry read data
    output logic                              MOVE_START,   // One-cycle launch pulse
    output var ptss_pkg::ptss_move_type       MOVE_CMD,     // Registered move command
    output logic                              BUSY,         // Move in progress
    output logic                              AUTO_ACTIVE   // Automatic mode in force
);
    typedef enum logic [1:0] {ST_IDLE, ST_LAUNCH, ST_MOVING} ptss_state_type;

    ////////////////////////////////////////////////////////////////////////////
    // Input filtering.
    logic [ptss_pkg::IN_W-1:0] raw_in, filt;
    logic [3:0]                filt_set_ff, nxt_filt_set;

    assign raw_in = {READY, SERVO_ON, REVERSE_START, FORWARD_START,
                     TABLE_SELECT, AUTO_MANUAL_SELECT};

    ptss_filter u_filter (
        .clk      (CLK_SYS),
        .rst      (RST),
        .raw_in   (raw_in),
        .filt_set (filt_set_ff),
        .filt_out (filt)
    );

    logic auto_f, fwd_f, rev_f, son_f, rdy_f;
    logic [3:0] sel_f;
    assign auto_f = filt[ptss_pkg::IN_AUTO];
    assign sel_f  = filt[ptss_pkg::IN_SEL_LSB +: 4];
    assign fwd_f  = filt[ptss_pkg::IN_FWD];
    assign rev_f  = filt[ptss_pkg::IN_REV];
    assign son_f  = filt[ptss_pkg::IN_SON];
    assign rdy_f  = filt[ptss_pkg::IN_READY];

    ////////////////////////////////////////////////////////////////////////////
    // Point table store; entry 0 is not a valid table and stays unused.
    ptss_pkg::ptss_entry_type table_ff [ptss_pkg::TABLE_COUNT];
    ptss_pkg::ptss_entry_type rdata_ff, nxt_rdata;
    logic                     tbl_valid_addr;

    function automatic logic table_ok(input logic [3:0] no);
        table_ok = (no >= 4'(ptss_pkg::TABLE_FIRST)) && (no <= 4'(ptss_pkg::TABLE_LAST));
    endfunction : table_ok

    always_comb begin
        tbl_valid_addr = table_ok(TBL_ADDR);
        nxt_rdata      = table_ff[TBL_ADDR];
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            rdata_ff <= '0;
            for (int i = 0; i < ptss_pkg::TABLE_COUNT; i++) begin
                table_ff[i] <= '0;
            end
        end else begin
            rdata_ff <= nxt_rdata;
            if (TBL_WE && tbl_valid_addr) begin
                table_ff[TBL_ADDR] <= TBL_WDATA;
            end
        end
    end

    assign TBL_RDATA = rdata_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Configuration capture.
    logic incr_ff, nxt_incr;
    logic [3:0] cmd_digit;

    // The system follows parameter zero in every state and holds on other digits; a running move keeps the copy taken at launch.
    always_comb begin
        cmd_digit    = PARAM0[ptss_pkg::CMD_DIGIT_LSB +: 4];
        nxt_filt_set = PARAM2_FILTER;
        nxt_incr     = incr_ff;
        if (cmd_digit == ptss_pkg::CMD_INCREMENTAL) begin
            nxt_incr = 1'b1;
        end else if (cmd_digit == ptss_pkg::CMD_ABSOLUTE) begin
            nxt_incr = 1'b0;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            incr_ff     <= 1'b0;
            filt_set_ff <= ptss_pkg::FILT_RESET;
        end else begin
            incr_ff     <= nxt_incr;
            filt_set_ff <= nxt_filt_set;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Start detection and launch sequencing.
    ptss_state_type          state_ff, nxt_state;
    logic                    fwd_d_ff, rev_d_ff, nxt_fwd_d, nxt_rev_d;
    logic                    start_ff, nxt_start;
    ptss_pkg::ptss_move_type cmd_ff, nxt_cmd;
    logic                    fwd_edge, rev_edge, permit, go_fwd, go_rev;
    ptss_pkg::ptss_entry_type sel_entry;

    always_comb begin
        nxt_fwd_d = fwd_f;
        nxt_rev_d = rev_f;
        fwd_edge  = fwd_f && !fwd_d_ff;
        rev_edge  = rev_f && !rev_d_ff;
        permit    = auto_f && son_f && rdy_f && !TROUBLE_FLAG;
        go_fwd    = permit && fwd_edge && table_ok(sel_f);
        go_rev    = permit && rev_edge && incr_ff && table_ok(sel_f);
        sel_entry = table_ff[sel_f];
        nxt_state = state_ff;
        nxt_start = 1'b0;
        nxt_cmd   = cmd_ff;
        case (state_ff)
            ST_IDLE: begin
                if (go_fwd || go_rev) begin
                    nxt_cmd.incremental = incr_ff;
                    nxt_cmd.reverse     = go_rev && !go_fwd;
                    nxt_cmd.table_no    = sel_f;
                    nxt_cmd.position    = sel_entry.position;
                    nxt_cmd.speed       = sel_entry.speed;
                    nxt_cmd.accel_time  = sel_entry.accel_time;
                    nxt_cmd.decel_time  = sel_entry.decel_time;
                    nxt_cmd.dwell_time  = sel_entry.dwell_time;
                    nxt_cmd.aux_func    = sel_entry.aux_func;
                    nxt_state           = ST_LAUNCH;
                end
            end
            ST_LAUNCH: begin
                nxt_start = 1'b1;
                nxt_state = ST_MOVING;
            end
            ST_MOVING: begin
                // Trouble or servo-off aborts the wait so a fresh start is possible.
                if (MOVE_DONE || TROUBLE_FLAG || !son_f) begin
                    nxt_state = ST_IDLE;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            state_ff <= ST_IDLE;
            fwd_d_ff <= 1'b0;
            rev_d_ff <= 1'b0;
            start_ff <= 1'b0;
            cmd_ff   <= '0;
        end else begin
            state_ff <= nxt_state;
            fwd_d_ff <= nxt_fwd_d;
            rev_d_ff <= nxt_rev_d;
            start_ff <= nxt_start;
            cmd_ff   <= nxt_cmd;
        end
    end

    assign MOVE_START  = start_ff;
    assign MOVE_CMD    = cmd_ff;
    assign BUSY        = (state_ff != ST_IDLE);
    assign AUTO_ACTIVE = auto_f;
endmodule : ptss_top
`default_nettype wire

// File: tb/ptss_ctrl_model.sv
// Behavioural servo system controller driving the digital command pins.
`default_nettype none
module ptss_ctrl_model #(
    parameter int LEAD = 6 // Cycles the selection settles before a start
) (
    input  wire logic     clk,      // System clock
    output var  logic     auto_sel, // Auto mode pin
    output var  logic [3:0] sel,    // Table select pins
    output var  logic     fwd,      // Forward start pin
    output var  logic     rev,      // Reverse start pin
    output var  logic     servo_on,      // Servo-on pin
    output var  logic     ready     // Ready pin
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {auto_sel, sel, fwd, rev, servo_on, ready} = '0;
    end

    task automatic lines(input logic a, input logic s, input logic r);
        @(posedge clk);
        auto_sel <= a;
        servo_on      <= s;
        ready    <= r;
    endtask : lines

    // The selection is settled well ahead so the filter never sees it move under a start.
    task automatic press(input logic [3:0] n, input logic r);
        @(posedge clk);
        sel <= n;
        repeat (LEAD) @(posedge clk);
        fwd <= !r;
        rev <= r;
    endtask : press

    task automatic lift;
        @(posedge clk);
        fwd <= 1'b0;
        rev <= 1'b0;
        repeat (LEAD) @(posedge clk);
    endtask : lift
endmodule : ptss_ctrl_model
`default_nettype wire

// File: tb/ptss_top_asserts.sv
// Concurrent checks on the ports of the point-table start sequencer.
`default_nettype none
module ptss_top_asserts (
    input wire logic                    CLK_SYS,       // System clock
    input wire logic                    RST,           // Synchronous reset
    input wire logic                    FORWARD_START, // Forward start pin
    input wire logic                    REVERSE_START, // Reverse start pin
    input wire logic [3:0]              TABLE_SELECT,  // Table select pins
    input wire logic                    TROUBLE_FLAG,  // Trouble state
    input wire logic [15:0]             PARAM0,        // Parameter zero
    input wire logic                    MOVE_DONE,     // Move finished
    input wire logic                    MOVE_START,    // Launch pulse
    input wire ptss_pkg::ptss_move_type MOVE_CMD,      // Move command
    input wire logic                    BUSY,          // Move in progress
    input wire logic                    AUTO_ACTIVE    // Automatic mode
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (RST);

    chk_pulse_one_cycle: assert property (MOVE_START |=> !MOVE_START)
        else $error("launch pulse longer than one cycle");
    chk_busy_leads_start: assert property (MOVE_START |-> $past(BUSY))
        else $error("launch without busy one cycle before");
    chk_auto_required: assert property ($rose(BUSY) |-> $past(AUTO_ACTIVE))
        else $error("move launched outside automatic mode");
    chk_abs_no_reverse: assert property (
        MOVE_START && !MOVE_CMD.incremental |-> !MOVE_CMD.reverse)
        else $error("reverse move in absolute system");
    chk_table_in_range: assert property (MOVE_START |-> MOVE_CMD.table_no != 4'h0)
        else $error("move launched from table zero");
    chk_cmd_held: assert property (MOVE_START |=> $stable(MOVE_CMD) [*3])
        else $error("move command changed after launch");
    chk_no_trouble: assert property ($rose(BUSY) |-> !$past(TROUBLE_FLAG))
        else $error("move launched during trouble");
    chk_done_clears: assert property (BUSY && MOVE_DONE && !$rose(BUSY) |=> !BUSY)
        else $error("busy kept after move done");
    chk_filter_delay: assert property (
        $rose(BUSY) |-> $past(FORWARD_START, 3) || $past(REVERSE_START, 3))
        else $error("start seen before input delay");
    chk_sel_sampled: assert property (
        MOVE_START |-> MOVE_CMD.table_no == $past(TABLE_SELECT, 2))
        else $error("table number differs from selection");
    chk_cmd_system: assert property (
        MOVE_START |-> MOVE_CMD.incremental == (PARAM0[3:0] == 4'h1))
        else $error("command system differs from parameter zero");

    cover property (MOVE_START && MOVE_CMD.reverse);
    cover property (MOVE_START && !MOVE_CMD.incremental);
    cover property (BUSY && MOVE_DONE);
endmodule : ptss_top_asserts
`default_nettype wire

// File: tb/tb_ptss_top.sv
// Self-checking bench for the point-table start sequencer.
`default_nettype none
module tb_ptss_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic CLK_SYS = 1'b0, RST = 1'b1, TROUBLE_FLAG = 1'b0, TBL_WE = 1'b0, MOVE_DONE = 1'b0;
    logic AUTO_MANUAL_SELECT, FORWARD_START, REVERSE_START, SERVO_ON, READY;
    logic MOVE_START, BUSY, AUTO_ACTIVE, got;
    logic [3:0] TABLE_SELECT, TBL_ADDR = 4'h0;
    logic [15:0] PARAM0 = 16'h0000;
    ptss_pkg::ptss_entry_type TBL_WDATA = '0, TBL_RDATA;
    ptss_pkg::ptss_move_type MOVE_CMD;
    int mismatches = 0, checked = 0;
    // Columns: incremental, reverse, table number, launch expected.
    localparam logic [6:0] ROWS [5] = '{7'h03, 7'h24, 7'h5f, 7'h67, 7'h00};
    always #5 CLK_SYS = ~CLK_SYS;

    ptss_ctrl_model i_ctrl (.clk(CLK_SYS), .auto_sel(AUTO_MANUAL_SELECT), .sel(TABLE_SELECT),
        .fwd(FORWARD_START), .rev(REVERSE_START), .servo_on(SERVO_ON), .ready(READY));
    ptss_top i_dut (.CLK_SYS, .RST, .AUTO_MANUAL_SELECT, .TABLE_SELECT, .FORWARD_START,
        .REVERSE_START, .SERVO_ON, .READY, .TROUBLE_FLAG, .PARAM0, .PARAM2_FILTER(4'h0),
        .TBL_WE, .TBL_ADDR, .TBL_WDATA, .MOVE_DONE, .TBL_RDATA, .MOVE_START, .MOVE_CMD,
        .BUSY, .AUTO_ACTIVE);

    ////////////////////////////////////////////////////////////////////////////////
    function automatic ptss_pkg::ptss_entry_type ent(input logic [3:0] n);
        ent = {32'h0000_0100 * n - 32'h0000_0400, {12'h000, n}, 16'h00c8, 16'h0096,
               {12'h000, n}, n[1:0]};
    endfunction : ent

    task automatic cmp_bit(input string nm, input logic e, input logic g);
        checked++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value %s expected %b seen %b", nm, e, g);
        end
    endtask : cmp_bit

    task automatic cmp_ent(input ptss_pkg::ptss_entry_type e, input ptss_pkg::ptss_entry_type g);
        checked++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value TBL_RDATA expected %h seen %h", e, g);
        end
    endtask : cmp_ent

    task automatic cmp_mov(input ptss_pkg::ptss_move_type e, input ptss_pkg::ptss_move_type g);
        checked++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value MOVE_CMD expected %h seen %h", e, g);
        end
    endtask : cmp_mov

    // Bounded watch for the launch pulse; the caller judges a missing one.
    task automatic wait_go(output logic g);
        g = 1'b0;
        for (int i = 0; i < 12 && g !== 1'b1; i++) begin
            @(posedge CLK_SYS);
            #1 g = MOVE_START;
        end
    endtask : wait_go

    task automatic done_pulse;
        @(posedge CLK_SYS) MOVE_DONE <= 1'b1;
        @(posedge CLK_SYS) MOVE_DONE <= 1'b0;
        @(posedge CLK_SYS);
    endtask : done_pulse

    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : end_of_test

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge CLK_SYS);
        RST <= 1'b0;
        #1 cmp_bit("BUSY", 1'b0, BUSY);
        cmp_bit("MOVE_START", 1'b0, MOVE_START);
        cmp_mov('0, MOVE_CMD);
        for (int n = 1; n <= 15; n++) begin
            @(posedge CLK_SYS) {TBL_WE, TBL_ADDR, TBL_WDATA} <= {1'b1, 4'(n), ent(4'(n))};
            @(posedge CLK_SYS) TBL_WE <= 1'b0;
            @(posedge CLK_SYS) #1 cmp_ent(ent(4'(n)), TBL_RDATA);
        end
        // Entry zero is not a table, so a write there must leave it empty.
        @(posedge CLK_SYS) {TBL_WE, TBL_ADDR, TBL_WDATA} <= {1'b1, 4'h0, ent(4'h5)};
        @(posedge CLK_SYS) TBL_WE <= 1'b0;
        @(posedge CLK_SYS) #1 cmp_ent('0, TBL_RDATA);
        $display("table store test done");
        i_ctrl.lines(1'b1, 1'b1, 1'b1);
        repeat (8) @(posedge CLK_SYS);
        #1 cmp_bit("AUTO_ACTIVE", 1'b1, AUTO_ACTIVE);
        foreach (ROWS[r]) begin
            PARAM0 <= {15'h0000, ROWS[r][6]};
            i_ctrl.press(ROWS[r][4:1], ROWS[r][5]);
            wait_go(got);
            cmp_bit("MOVE_START", ROWS[r][0], got);
            if (ROWS[r][0]) begin
                cmp_mov({ROWS[r][6:1], ent(ROWS[r][4:1])}, MOVE_CMD);
                if (got !== 1'b1) end_of_test();
            end
            done_pulse();
            #1 cmp_bit("BUSY", 1'b0, BUSY);
            wait_go(got);
            cmp_bit("relaunch", 1'b0, got);
            i_ctrl.lift();
            $display("row %0d test done", r);
        end
        for (int k = 0; k < 4; k++) begin
            TROUBLE_FLAG <= (k == 0);
            i_ctrl.lines(k != 2, k != 1, k != 3);
            i_ctrl.press(4'h4, 1'b0);
            wait_go(got);
            cmp_bit("refused start", 1'b0, got);
            cmp_bit("AUTO_ACTIVE", k != 2, AUTO_ACTIVE);
            i_ctrl.lift();
            TROUBLE_FLAG <= 1'b0;
            i_ctrl.lines(1'b1, 1'b1, 1'b1);
            $display("refusal %0d test done", k);
        end
        // A start during a move is lost, trouble aborts the move, and reset clears one.
        i_ctrl.press(4'h2, 1'b0);
        wait_go(got);
        cmp_bit("MOVE_START", 1'b1, got);
        if (got !== 1'b1) end_of_test();
        i_ctrl.lift();
        i_ctrl.press(4'h2, 1'b0);
        wait_go(got);
        cmp_bit("busy start", 1'b0, got);
        TROUBLE_FLAG <= 1'b1;
        @(posedge CLK_SYS) TROUBLE_FLAG <= 1'b0;
        @(posedge CLK_SYS) #1 cmp_bit("BUSY", 1'b0, BUSY);
        i_ctrl.lift();
        i_ctrl.press(4'h5, 1'b0);
        wait_go(got);
        cmp_bit("MOVE_START", 1'b1, got);
        if (got !== 1'b1) end_of_test();
        i_ctrl.lift();
        RST <= 1'b1;
        repeat (2) @(posedge CLK_SYS);
        RST <= 1'b0;
        #1 cmp_bit("BUSY", 1'b0, BUSY);
        cmp_mov('0, MOVE_CMD);
        cmp_bit("AUTO_ACTIVE", 1'b0, AUTO_ACTIVE);
        $display("awkward cases test done");
        end_of_test();
    end
endmodule : tb_ptss_top

bind ptss_top ptss_top_asserts i_chk (.CLK_SYS, .RST, .FORWARD_START, .REVERSE_START,
    .TABLE_SELECT, .TROUBLE_FLAG, .PARAM0, .MOVE_DONE, .MOVE_START, .MOVE_CMD, .BUSY,
    .AUTO_ACTIVE);
`default_nettype wire
